// *** design/sicr_ctrl.sv ***
`timescale 1ns/10ps
// system integrity control/status register with two pages at one address
module sicr_ctrl (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,

    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,

    // analog and clock monitors (asynchronous levels)
    input wire logic i_supply_low,
    input wire logic i_osc_stopped,
    input wire logic i_synth_locked,
    input wire logic i_in_circuit_session,

    // reset controller events (one-cycle pulses, same clock)
    input wire logic i_dog_reset_event,
    input wire logic i_brownout_reset_event,

    // option bits (static levels, same clock)
    input wire logic i_opt_brownout_enable,
    input wire logic i_opt_synth_clock,

    // cpu interrupt side
    input wire logic i_cpu_irq_mask,
    input wire logic i_supply_irq_ack,
    input wire logic i_guard_irq_ack,
    output logic o_supply_irq,
    output logic o_guard_irq,

    // clock tree controls
    output logic o_osc_ctrl_ground_sel,
    output logic o_synth_enable,
    output logic o_clock_source_select
);
    typedef struct packed {
        logic page;
        logic supply_warn_irq_enable;
        logic brownout_reset_flag;
        logic clock_guard_irq_enable;
        logic clock_guard_detected;
        logic dog_reset_flag;
        logic osc_ctrl_ground_sel;
        logic synth_enable;
        logic clock_source_select;
        logic supply_prev;
        logic osc_prev;
        logic icc_prev;
        logic supply_pend;
        logic guard_pend;
        logic supply_irq;
        logic guard_irq;
        logic eff_select;
        logic eff_enable;
        logic [7:0] rdata;
    } sicr_state_type;

    sicr_state_type state;
    sicr_state_type next_state;

    logic [sicr_pkg::SYNC_W-1:0] mon_async;
    logic [sicr_pkg::SYNC_W-1:0] mon_sync;
    logic supply_flag;
    logic osc_lost;
    logic lock_flag;
    logic icc_on;

    // every monitor level crosses two flops before use
    assign mon_async[sicr_pkg::S_SUPPLY] = i_supply_low;
    assign mon_async[sicr_pkg::S_OSC] = i_osc_stopped;
    assign mon_async[sicr_pkg::S_LOCK] = i_synth_locked;
    assign mon_async[sicr_pkg::S_ICC] = i_in_circuit_session;

    sicr_sync #(
        .W(sicr_pkg::SYNC_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_async(mon_async),
        .o_sync(mon_sync)
    );

    assign supply_flag = mon_sync[sicr_pkg::S_SUPPLY];
    assign osc_lost = mon_sync[sicr_pkg::S_OSC];
    assign lock_flag = mon_sync[sicr_pkg::S_LOCK];
    assign icc_on = mon_sync[sicr_pkg::S_ICC];

    // build the byte seen at the register address for the current page
    function automatic logic [7:0] page_view(
        input sicr_state_type s,
        input logic sup,
        input logic lock,
        input logic brown_opt
    );
        logic [7:0] v;
        v = 8'h00;
        v[sicr_pkg::PAGE_BIT] = s.page;
        if (!s.page) begin
            v[sicr_pkg::SUP_IE_BIT] = s.supply_warn_irq_enable;
            v[sicr_pkg::SUP_FLAG_BIT] = sup;
            // undefined when the detector is optioned out; shown as zero
            v[sicr_pkg::BROWN_BIT] = s.brownout_reset_flag & brown_opt;
            v[sicr_pkg::GUARD_IE_BIT] = s.clock_guard_irq_enable;
            v[sicr_pkg::GUARD_DET_BIT] = s.clock_guard_detected & s.synth_enable;
            v[sicr_pkg::DOG_BIT] = s.dog_reset_flag;
        end else begin
            v[sicr_pkg::VCO_BIT] = s.osc_ctrl_ground_sel;
            v[sicr_pkg::LOCK_BIT] = lock;
            v[sicr_pkg::SYNTH_EN_BIT] = s.synth_enable;
            v[sicr_pkg::CLK_SEL_BIT] = s.clock_source_select;
        end
        return v;
    endfunction

    logic hit_wr;
    logic hit_rd;
    logic wr_p0;
    logic wr_p1;
    logic icc_rise;
    logic supply_toggle;
    logic osc_fall_edge;
    logic new_en;
    logic new_sel;

    // decode the single register address
    assign hit_wr = i_wr && (i_addr == sicr_pkg::REG_ADDR);
    assign hit_rd = i_rd && (i_addr == sicr_pkg::REG_ADDR);
    assign wr_p0 = hit_wr && !state.page;
    assign wr_p1 = hit_wr && state.page;

    // edges of synchronised monitor levels
    assign icc_rise = icc_on && !state.icc_prev;
    assign supply_toggle = supply_flag ^ state.supply_prev;
    assign osc_fall_edge = osc_lost && !state.osc_prev;

    // page-1 clock controls after a write, with the refusals applied
    always_comb begin
        new_en = state.synth_enable;
        new_sel = state.clock_source_select;
        if (wr_p1) begin
            // disabling refused while synth clock is selected
            if (i_wdata[sicr_pkg::SYNTH_EN_BIT] || state.clock_source_select) begin
                new_en = i_wdata[sicr_pkg::SYNTH_EN_BIT] | state.clock_source_select;
            end else begin
                new_en = 1'b0;
            end
            // selecting synth clock needs the synth enabled
            if (i_wdata[sicr_pkg::CLK_SEL_BIT] && !new_en) begin
                new_sel = state.clock_source_select;
            end else begin
                new_sel = i_wdata[sicr_pkg::CLK_SEL_BIT];
            end
            // clearing both at once: release select first, then enable
            if (!i_wdata[sicr_pkg::CLK_SEL_BIT] && !i_wdata[sicr_pkg::SYNTH_EN_BIT]) begin
                new_sel = 1'b0;
                new_en = state.clock_source_select;
            end
        end
        // a session forces both on, software may back out later
        if (icc_rise) begin
            new_en = 1'b1;
            new_sel = 1'b1;
        end
    end

    // main next-state process
    always_comb begin
        next_state = state;

        // edge history
        next_state.supply_prev = supply_flag;
        next_state.osc_prev = osc_lost;
        next_state.icc_prev = icc_on;

        // page select is writable from either page
        if (hit_wr) begin
            next_state.page = i_wdata[sicr_pkg::PAGE_BIT];
        end

        // page-0 enables; flags only accept a zero write
        if (wr_p0) begin
            next_state.supply_warn_irq_enable = i_wdata[sicr_pkg::SUP_IE_BIT];
            next_state.clock_guard_irq_enable = i_wdata[sicr_pkg::GUARD_IE_BIT];
            if (!i_wdata[sicr_pkg::BROWN_BIT]) begin
                next_state.brownout_reset_flag = 1'b0;
            end
            if (!i_wdata[sicr_pkg::DOG_BIT]) begin
                next_state.dog_reset_flag = 1'b0;
            end
            // supply flag and guard flag bits are not writable
        end

        // reset-source history: set wins over software clear
        if (i_brownout_reset_event) begin
            next_state.brownout_reset_flag = 1'b1;
            next_state.dog_reset_flag = 1'b0;
        end else if (i_dog_reset_event) begin
            // brownout flag left untouched so the first failure stays visible
            next_state.dog_reset_flag = 1'b1;
        end

        // guard flag: read clears only after the oscillator is back
        if (hit_rd && !state.page && !osc_lost) begin
            next_state.clock_guard_detected = 1'b0;
        end
        if (osc_fall_edge && state.synth_enable) begin
            next_state.clock_guard_detected = 1'b1;
        end
        if (!state.synth_enable) begin
            next_state.clock_guard_detected = 1'b0;
        end

        // oscillator mode bit, forced by a session
        if (wr_p1) begin
            next_state.osc_ctrl_ground_sel = i_wdata[sicr_pkg::VCO_BIT];
        end
        if (icc_rise) begin
            next_state.osc_ctrl_ground_sel = 1'b1;
        end

        // synth enable and clock select after refusals
        next_state.synth_enable = new_en;
        next_state.clock_source_select = new_sel;

        // option-fixed source overrides register select
        next_state.eff_select = i_opt_synth_clock | new_sel;
        next_state.eff_enable = i_opt_synth_clock | new_en;

        // supply pending: toggle sets, service entry clears, set wins
        if (i_supply_irq_ack) begin
            next_state.supply_pend = 1'b0;
        end
        if (supply_toggle && state.supply_warn_irq_enable) begin
            next_state.supply_pend = 1'b1;
        end
        if (!state.supply_warn_irq_enable) begin
            next_state.supply_pend = 1'b0;
        end

        // guard pending: only while the synth is on
        if (i_guard_irq_ack) begin
            next_state.guard_pend = 1'b0;
        end
        if (osc_fall_edge && state.clock_guard_irq_enable && state.synth_enable) begin
            next_state.guard_pend = 1'b1;
        end
        if (!state.clock_guard_irq_enable || !state.synth_enable) begin
            next_state.guard_pend = 1'b0;
        end

        // cpu mask gates the request lines
        next_state.supply_irq = next_state.supply_pend & ~i_cpu_irq_mask;
        next_state.guard_irq = next_state.guard_pend & ~i_cpu_irq_mask;

        // read data stands only in the cycle after the strobe
        if (hit_rd) begin
            next_state.rdata = page_view(state, supply_flag, lock_flag, i_opt_brownout_enable);
        end else begin
            next_state.rdata = 8'h00;
        end
    end

    // single register stage for all state
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '0;
            state.rdata <= sicr_pkg::REG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign o_rdata = state.rdata;
    assign o_supply_irq = state.supply_irq;
    assign o_guard_irq = state.guard_irq;
    assign o_osc_ctrl_ground_sel = state.osc_ctrl_ground_sel;
    assign o_synth_enable = state.eff_enable;
    assign o_clock_source_select = state.eff_select;
endmodule // sicr_ctrl

// *** design/sicr_pkg.sv ***
package sicr_pkg;
    // register address and reset value
    localparam logic [7:0] REG_ADDR = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // common bit
    localparam int PAGE_BIT = 7;
    // page 0 layout
    localparam int SUP_IE_BIT = 6;
    localparam int SUP_FLAG_BIT = 5;
    localparam int BROWN_BIT = 4;
    localparam int GUARD_IE_BIT = 2;
    localparam int GUARD_DET_BIT = 1;
    localparam int DOG_BIT = 0;
    // page 1 layout
    localparam int VCO_BIT = 5;
    localparam int LOCK_BIT = 4;
    localparam int SYNTH_EN_BIT = 3;
    localparam int CLK_SEL_BIT = 1;
    // synchroniser lane numbers
    localparam int SYNC_W = 4;
    localparam int S_SUPPLY = 0;
    localparam int S_OSC = 1;
    localparam int S_LOCK = 2;
    localparam int S_ICC = 3;
endpackage

// *** design/sicr_sync.sv ***
`timescale 1ns/10ps
// two-flop synchroniser, one lane per bit
module sicr_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sicr_sync_type;

    sicr_sync_type state;
    sicr_sync_type next_state;

    // meta feeds only the second stage
    always_comb begin
        next_state = state;
        for (int k = 0; k < W; k++) begin
            next_state.meta[k] = i_async[k];
            next_state.stable[k] = state.meta[k];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.stable;
endmodule // sicr_sync

// *** sim/sicr_ctrl_asserts.sv ***
`timescale 1ns/10ps
// watches the register port and clock controls from the outside only
module sicr_ctrl_asserts (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // monitors, events, options
    input wire logic i_supply_low,
    input wire logic i_osc_stopped,
    input wire logic i_synth_locked,
    input wire logic i_in_circuit_session,
    input wire logic i_dog_reset_event,
    input wire logic i_brownout_reset_event,
    input wire logic i_opt_brownout_enable,
    input wire logic i_opt_synth_clock,
    // cpu side and clock tree
    input wire logic i_cpu_irq_mask,
    input wire logic i_supply_irq_ack,
    input wire logic i_guard_irq_ack,
    input wire logic o_supply_irq,
    input wire logic o_guard_irq,
    input wire logic o_osc_ctrl_ground_sel,
    input wire logic o_synth_enable,
    input wire logic o_clock_source_select
);
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    chk_rdata_idle: assert property (!($past(i_rd) && $past(i_addr) == 8'h00) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    chk_reserved_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h00 |->
        (o_rdata[7] ? (o_rdata & 8'h45) == 8'h00 : !o_rdata[3])) else $error("reserved bit set");
    chk_guard_forced: assert property ($past(i_rd) && $past(i_addr) == 8'h00 && !o_rdata[7]
        && !$past(o_synth_enable) && !$past(o_synth_enable, 2) |-> !o_rdata[1])
        else $error("guard flag seen with synth off");
    chk_mask_blocks: assert property ($past(i_cpu_irq_mask) |-> !o_supply_irq && !o_guard_irq)
        else $error("irq while masked");
    chk_guard_rise: assert property ($rose(o_guard_irq) |-> $past(o_synth_enable))
        else $error("guard irq with synth off");
    chk_opt_force: assert property ($past(i_opt_synth_clock) |-> o_synth_enable && o_clock_source_select)
        else $error("option not forcing synth clock");
    chk_sel_needs_en: assert property (o_clock_source_select |-> o_synth_enable)
        else $error("synth clock selected while disabled");
    chk_en_kept: assert property ($fell(o_synth_enable) && !$past(i_opt_synth_clock, 2)
        |-> !$past(o_clock_source_select)) else $error("synth disabled while selected");
endmodule // sicr_ctrl_asserts

bind sicr_ctrl sicr_ctrl_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_low(i_supply_low),
    .i_osc_stopped(i_osc_stopped), .i_synth_locked(i_synth_locked),
    .i_in_circuit_session(i_in_circuit_session), .i_dog_reset_event(i_dog_reset_event),
    .i_brownout_reset_event(i_brownout_reset_event), .i_opt_brownout_enable(i_opt_brownout_enable),
    .i_opt_synth_clock(i_opt_synth_clock), .i_cpu_irq_mask(i_cpu_irq_mask),
    .i_supply_irq_ack(i_supply_irq_ack), .i_guard_irq_ack(i_guard_irq_ack),
    .o_supply_irq(o_supply_irq), .o_guard_irq(o_guard_irq),
    .o_osc_ctrl_ground_sel(o_osc_ctrl_ground_sel), .o_synth_enable(o_synth_enable),
    .o_clock_source_select(o_clock_source_select));

// *** sim/tb_system_integrity_control_status.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_system_integrity_control_status;
    // stimulus, all valued at time zero
    logic i_sys_clk = 1'h0, i_rstn = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
    logic i_supply_low = 1'h0, i_osc_stopped = 1'h0, i_synth_locked = 1'h0, i_session = 1'h0;
    logic i_dog_ev = 1'h0, i_brown_ev = 1'h0, i_opt_brown = 1'h1, i_opt_synth = 1'h0;
    logic i_mask = 1'h0, i_sack = 1'h0, i_gack = 1'h0;
    logic [7:0] o_rdata;
    logic o_supply_irq, o_guard_irq, o_ground_sel, o_synth_enable, o_clock_source_select;
    int bad_count = 0;
    int checks = 0;
    sicr_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_low(i_supply_low),
        .i_osc_stopped(i_osc_stopped), .i_synth_locked(i_synth_locked),
        .i_in_circuit_session(i_session), .i_dog_reset_event(i_dog_ev),
        .i_brownout_reset_event(i_brown_ev), .i_opt_brownout_enable(i_opt_brown),
        .i_opt_synth_clock(i_opt_synth), .i_cpu_irq_mask(i_mask), .i_supply_irq_ack(i_sack),
        .i_guard_irq_ack(i_gack), .o_supply_irq(o_supply_irq), .o_guard_irq(o_guard_irq),
        .o_osc_ctrl_ground_sel(o_ground_sel), .o_synth_enable(o_synth_enable),
        .o_clock_source_select(o_clock_source_select));
    // 25 MHz clock
    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // let n edges pass, then look once outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_sys_clk);
        i_wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_sys_clk);
        i_rd <= 1'h0;
        #1;
        `CHK(o_rdata, exp)
    endtask
    // one-cycle pulses: dog, brownout, supply ack, guard ack
    task automatic pulse(input logic [3:0] p);
        @(posedge i_sys_clk);
        {i_dog_ev, i_brown_ev, i_sack, i_gack} <= p;
        @(posedge i_sys_clk);
        {i_dog_ev, i_brown_ev, i_sack, i_gack} <= 4'h0;
    endtask
    // monitor levels pass a synchroniser, so give them time to land
    task automatic lv(input logic [3:0] v);
        @(posedge i_sys_clk);
        {i_supply_low, i_osc_stopped, i_synth_locked, i_session} <= v;
        tick(6);
    endtask
    task automatic s_page;
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h80);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h80);
        wr(8'h00, 8'h00);
    endtask
    task automatic s_supply;
        wr(8'h00, 8'h40);
        lv(4'h8);
        `CHK(o_supply_irq, 1'h1)
        rd(8'h00, 8'h60);
        @(posedge i_sys_clk) i_mask <= 1'h1;
        tick(2);
        `CHK(o_supply_irq, 1'h0)
        @(posedge i_sys_clk) i_mask <= 1'h0;
        tick(2);
        `CHK(o_supply_irq, 1'h1)
        pulse(4'h2);
        tick(2);
        `CHK(o_supply_irq, 1'h0)
        wr(8'h00, 8'h57);
        rd(8'h00, 8'h64);
        lv(4'h0);
        `CHK(o_supply_irq, 1'h1)
        wr(8'h00, 8'h00);
        tick(2);
        `CHK(o_supply_irq, 1'h0)
    endtask
    task automatic s_flags;
        pulse(4'h8);
        rd(8'h00, 8'h01);
        pulse(4'h4);
        rd(8'h00, 8'h10);
        // detector optioned out: the stored flag must not show
        @(posedge i_sys_clk) i_opt_brown <= 1'h0;
        rd(8'h00, 8'h00);
        @(posedge i_sys_clk) i_opt_brown <= 1'h1;
        pulse(4'h8);
        rd(8'h00, 8'h11);
        wr(8'h00, 8'h10);
        rd(8'h00, 8'h10);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
    endtask
    task automatic s_synth;
        // a page-0 write only flips the page; the enable needs a page-1 write
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h88);
        rd(8'h00, 8'h88);
        lv(4'h2);
        rd(8'h00, 8'h98);
        wr(8'h00, 8'h8a);
        tick(2);
        `CHK(o_clock_source_select, 1'h1)
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h98);
        wr(8'h00, 8'h82);
        rd(8'h00, 8'h90);
        wr(8'h00, 8'ha0);
        tick(2);
        `CHK(o_ground_sel, 1'h1)
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h90);
    endtask
    task automatic s_guard;
        // still on page 1: enable synth and return to page 0 in one write
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h04);
        lv(4'h6);
        `CHK(o_guard_irq, 1'h1)
        rd(8'h00, 8'h06);
        rd(8'h00, 8'h06);
        lv(4'h2);
        rd(8'h00, 8'h06);
        rd(8'h00, 8'h04);
        pulse(4'h1);
        tick(2);
        `CHK(o_guard_irq, 1'h0)
        // keep the guard enable, then switch synth off from page 1
        wr(8'h00, 8'h84);
        wr(8'h00, 8'h00);
        lv(4'h6);
        rd(8'h00, 8'h04);
        `CHK(o_guard_irq, 1'h0)
        lv(4'h2);
    endtask
    task automatic s_session;
        wr(8'h00, 8'h80);
        lv(4'h3);
        rd(8'h00, 8'hba);
        `CHK(o_clock_source_select, 1'h1)
        wr(8'h00, 8'h88);
        rd(8'h00, 8'h98);
        lv(4'h2);
    endtask
    task automatic s_option;
        @(posedge i_sys_clk) i_opt_synth <= 1'h1;
        tick(3);
        `CHK(o_clock_source_select, 1'h1)
        wr(8'h00, 8'h80);
        tick(2);
        `CHK(o_synth_enable, 1'h1)
        `CHK(o_clock_source_select, 1'h1)
        @(posedge i_sys_clk) i_opt_synth <= 1'h0;
        tick(3);
        `CHK(o_synth_enable, 1'h0)
    endtask
    task automatic report_and_stop;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
    // reset for five cycles, then every scenario in turn
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rstn <= 1'h1;
        s_page();
        s_supply();
        s_flags();
        s_synth();
        s_guard();
        s_session();
        s_option();
        report_and_stop();
    end
endmodule // tb_system_integrity_control_status
